// file: core/gth_pkg.sv
// constants shared by the talker framer and the hold-off logic
// assumes a single 40 MHz system clock for every file that imports it
package gth_pkg;
   // terminator byte values
   localparam logic [7:0] CHAR_CR = 8'h0D;
   localparam logic [7:0] CHAR_LF = 8'h0A;
   // terminator select codes
   localparam logic [1:0] TERM_CR_LF = 2'h0;
   localparam logic [1:0] TERM_LF_CR = 2'h1;
   localparam logic [1:0] TERM_CR = 2'h2;
   localparam logic [1:0] TERM_LF = 2'h3;
   localparam logic [1:0] TERM_RESET = TERM_CR_LF;
   // eoi / hold-off codes
   localparam logic [2:0] EH_BOTH_ON = 3'h0;
   localparam logic [2:0] EH_EOI_OFF = 3'h1;
   localparam logic [2:0] EH_HOLD_OFF = 3'h2;
   localparam logic [2:0] EH_BOTH_OFF = 3'h4;
   localparam logic [2:0] EH_RESET = EH_BOTH_ON;
   // kind of command string being executed
   localparam logic [1:0] KIND_PLAIN = 2'h0;
   localparam logic [1:0] KIND_FMT = 2'h1;
   localparam logic [1:0] KIND_WAVE = 2'h2;
   // timing
   localparam int CLK_HZ = 40000000;
   localparam int HOLD_FMT_MS = 61;
   localparam int HOLD_WAVE_MS = 200;
   localparam int HOLD_FMT_CYC = HOLD_FMT_MS * (CLK_HZ / 1000);
   localparam int HOLD_WAVE_CYC = HOLD_WAVE_MS * (CLK_HZ / 1000);
   localparam int HOLD_W = 24;
   // framer states
   typedef enum logic [1:0] {
      FR_DATA,
      FR_TERM1,
      FR_TERM2
   } gth_fr_t;
endpackage : gth_pkg

// file: core/gth_buf2.sv
// two-entry valid/ready buffer between the data source and the framer
// assumes both sides on sys_clk_i; ready toward the source comes only from the registered count
`timescale 1ns/1ps
module gth_buf2 #(
   parameter int WIDTH = 9
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // filling side
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   // draining side
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i
);
   typedef struct packed {
      logic [1:0][WIDTH-1:0] mem;
      logic wr_ptr;
      logic rd_ptr;
      logic [1:0] count;
   } gth_buf_t;

   gth_buf_t s_q;
   gth_buf_t s_d;
   logic push;
   logic pop;

   // honest full and empty flags
   assign in_ready_o = (s_q.count != 2'h2);
   assign out_valid_o = (s_q.count != 2'h0);
   assign out_data_o = s_q.mem[s_q.rd_ptr];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   // pointer and occupancy update
   always_comb begin
      s_d = s_q;
      if (push) begin
         s_d.mem[s_q.wr_ptr] = in_data_i;
         s_d.wr_ptr = ~s_q.wr_ptr;
      end
      if (pop) begin
         s_d.rd_ptr = ~s_q.rd_ptr;
      end
      if (push && !pop) begin
         s_d.count = s_q.count + 2'h1;
      end else if (pop && !push) begin
         s_d.count = s_q.count - 2'h1;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule : gth_buf2

// file: core/gth_core.sv
// talker terminator framing and listener hold-off for the instrument bus port
// assumes command parsing and the bus handshake engine sit outside on sys_clk_i
`timescale 1ns/1ps
module gth_core
   import gth_pkg::*;
#(
   parameter int HOLD_FMT_CYCLES = HOLD_FMT_CYC,
   parameter int HOLD_WAVE_CYCLES = HOLD_WAVE_CYC
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // outgoing data string from the instrument
   input wire logic src_valid_i,
   input wire logic [7:0] src_data_i,
   input wire logic src_last_i,
   output logic src_ready_o,
   // framed bytes toward the bus handshake engine
   output logic tx_valid_o,
   output logic [7:0] tx_data_o,
   output logic tx_eoi_o,
   input wire logic tx_ready_i,
   // parsed settings, staged until processing ends; term_disable_i acts at once
   input wire logic term_set_i,
   input wire logic [1:0] term_code_i,
   input wire logic eh_set_i,
   input wire logic [2:0] eh_code_i,
   input wire logic term_disable_i,
   // command execution events
   input wire logic exec_i,
   input wire logic [1:0] exec_kind_i,
   input wire logic proc_done_i,
   input wire logic dev_clear_i,
   // bus hold-off and live settings
   output logic nrfd_hold_o,
   output logic [1:0] term_sel_o,
   output logic eoi_en_o,
   output logic hold_en_o
);
   typedef struct packed {
      logic [1:0] term_sel;
      logic eoi_en;
      logic hold_en;
      logic term_pend;
      logic [1:0] term_stage;
      logic eh_pend;
      logic eoi_stage;
      logic hold_stage;
      logic hold;
      logic done_seen;
      logic [HOLD_W-1:0] hold_cnt;
      gth_fr_t fr;
      logic tx_valid;
      logic [7:0] tx_data;
      logic tx_eoi;
   } gth_state_t;

   localparam logic [HOLD_W-1:0] FMT_CNT = HOLD_W'(HOLD_FMT_CYCLES);
   localparam logic [HOLD_W-1:0] WAVE_CNT = HOLD_W'(HOLD_WAVE_CYCLES);

   gth_state_t s_q;
   gth_state_t s_d;
   logic buf_valid;
   logic buf_ready;
   logic [8:0] buf_data;
   logic can_load;
   logic [7:0] term_first;
   logic [7:0] term_second;
   logic term_two;

   // stall absorber so a receiver stall loses no word
   gth_buf2 #(
      .WIDTH(9)
   ) u_buf (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .in_valid_i(src_valid_i),
      .in_data_i({src_last_i, src_data_i}),
      .in_ready_o(src_ready_o),
      .out_valid_o(buf_valid),
      .out_data_o(buf_data),
      .out_ready_i(buf_ready)
   );

   always_comb begin
      term_first = ((s_q.term_sel == TERM_LF_CR) || (s_q.term_sel == TERM_LF)) ? CHAR_LF : CHAR_CR;
      term_second = (s_q.term_sel == TERM_CR_LF) ? CHAR_LF : CHAR_CR;
      term_two = (s_q.term_sel == TERM_CR_LF) || (s_q.term_sel == TERM_LF_CR);
   end

   // output register may load when empty or being taken
   assign can_load = !s_q.tx_valid || tx_ready_i;
   assign buf_ready = can_load && (s_q.fr == FR_DATA);

   always_comb begin
      s_d = s_q;
      if (tx_ready_i) begin
         s_d.tx_valid = 1'b0;
      end
      // framer: data bytes, then the terminator after the sequence end
      case (s_q.fr)
         FR_DATA: begin
            if (can_load && buf_valid) begin
               s_d.tx_valid = 1'b1;
               s_d.tx_data = buf_data[7:0];
               // end marker only at whole end
               s_d.tx_eoi = buf_data[8] && s_q.eoi_en && term_disable_i;
               if (buf_data[8] && !term_disable_i) begin
                  s_d.fr = FR_TERM1;
               end
            end
         end
         FR_TERM1: begin
            if (can_load) begin
               s_d.tx_valid = 1'b1;
               s_d.tx_data = term_first;
               s_d.tx_eoi = !term_two && s_q.eoi_en;
               s_d.fr = term_two ? FR_TERM2 : FR_DATA;
            end
         end
         FR_TERM2: begin
            if (can_load) begin
               s_d.tx_valid = 1'b1;
               s_d.tx_data = term_second;
               s_d.tx_eoi = s_q.eoi_en;
               s_d.fr = FR_DATA;
            end
         end
         default: begin
            s_d.fr = FR_DATA;
         end
      endcase

      // staging of parsed settings; unknown codes are dropped
      if (term_set_i) begin
         s_d.term_pend = 1'b1;
         s_d.term_stage = term_code_i;
      end
      if (eh_set_i) begin
         case (eh_code_i)
            EH_BOTH_ON: begin
               s_d.eh_pend = 1'b1;
               s_d.eoi_stage = 1'b1;
               s_d.hold_stage = 1'b1;
            end
            EH_EOI_OFF: begin
               s_d.eh_pend = 1'b1;
               s_d.eoi_stage = 1'b0;
               s_d.hold_stage = 1'b1;
            end
            EH_HOLD_OFF: begin
               s_d.eh_pend = 1'b1;
               s_d.eoi_stage = 1'b1;
               s_d.hold_stage = 1'b0;
            end
            EH_BOTH_OFF: begin
               s_d.eh_pend = 1'b1;
               s_d.eoi_stage = 1'b0;
               s_d.hold_stage = 1'b0;
            end
            default: begin
               s_d.eh_pend = s_q.eh_pend;
            end
         endcase
      end

      if (proc_done_i) begin
         if (s_q.term_pend) begin
            s_d.term_sel = s_q.term_stage;
         end
         if (s_q.eh_pend) begin
            s_d.eoi_en = s_q.eoi_stage;
            s_d.hold_en = s_q.hold_stage;
         end
         s_d.term_pend = term_set_i;
         s_d.eh_pend = eh_set_i && s_d.eh_pend;
      end

      if (dev_clear_i) begin
         s_d.term_sel = TERM_RESET;
         s_d.eoi_en = 1'b1;
         s_d.hold_en = 1'b1;
         s_d.term_pend = 1'b0;
         s_d.eh_pend = 1'b0;
      end

      // hold timer counts the typical minimum for slow commands
      if (s_q.hold_cnt != '0) begin
         s_d.hold_cnt = s_q.hold_cnt - HOLD_W'(1);
      end
      if (proc_done_i) begin
         s_d.done_seen = 1'b1;
      end
      if (s_q.hold && s_q.done_seen && (s_q.hold_cnt == '0)) begin
         s_d.hold = 1'b0;
      end
      if (exec_i && s_q.hold_en) begin
         s_d.hold = 1'b1;
         s_d.done_seen = 1'b0;
         if (exec_kind_i == KIND_FMT) begin
            s_d.hold_cnt = FMT_CNT;
         end else if (exec_kind_i == KIND_WAVE) begin
            s_d.hold_cnt = WAVE_CNT;
         end else begin
            s_d.hold_cnt = '0;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         s_q <= '0;
         s_q.term_sel <= TERM_RESET;
         s_q.eoi_en <= 1'b1;
         s_q.hold_en <= 1'b1;
         s_q.fr <= FR_DATA;
      end else begin
         s_q <= s_d;
      end
   end

   // registered outputs
   assign tx_valid_o = s_q.tx_valid;
   assign tx_data_o = s_q.tx_data;
   assign tx_eoi_o = s_q.tx_eoi;
   assign nrfd_hold_o = s_q.hold;
   assign term_sel_o = s_q.term_sel;
   assign eoi_en_o = s_q.eoi_en;
   assign hold_en_o = s_q.hold_en;
endmodule : gth_core

// file: verification/gth_core_assertions.sv
// port checker for the framer and hold-off block
// assumes a bind onto gth_core and the one system clock
`timescale 1ns/1ps
module gth_core_chk
   import gth_pkg::*;
#(
   parameter int HOLD_FMT_CYCLES = HOLD_FMT_CYC,
   parameter int HOLD_WAVE_CYCLES = HOLD_WAVE_CYC
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // framed byte side
   input wire logic tx_valid_o,
   input wire logic [7:0] tx_data_o,
   input wire logic tx_eoi_o,
   input wire logic tx_ready_i,
   input wire logic term_disable_i,
   // command events
   input wire logic exec_i,
   input wire logic [1:0] exec_kind_i,
   input wire logic proc_done_i,
   input wire logic dev_clear_i,
   // hold-off and live settings
   input wire logic nrfd_hold_o,
   input wire logic [1:0] term_sel_o,
   input wire logic eoi_en_o,
   input wire logic hold_en_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   // a byte and its eoi flag travel together
   chk_tx_stand: assert property (tx_valid_o && !tx_ready_i |=>
      tx_valid_o && $stable({tx_data_o, tx_eoi_o})) else $error("tx byte moved under stall");
   chk_eoi_term: assert property (tx_valid_o && tx_eoi_o && !term_disable_i |->
      tx_data_o == CHAR_CR || tx_data_o == CHAR_LF) else $error("eoi on a non terminator");
   chk_eoi_gate: assert property (tx_valid_o && tx_eoi_o |-> eoi_en_o)
      else $error("eoi while disabled");
   chk_clear_def: assert property (dev_clear_i |=>
      term_sel_o == TERM_RESET && eoi_en_o && hold_en_o) else $error("clear missed defaults");
   chk_live_hold: assert property (!proc_done_i && !dev_clear_i |=>
      $stable({term_sel_o, eoi_en_o, hold_en_o})) else $error("settings moved early");
   chk_nrfd_rise: assert property (exec_i && hold_en_o |=> nrfd_hold_o)
      else $error("no hold after execute");
   chk_exec_skip: assert property (exec_i && !hold_en_o && !nrfd_hold_o |=>
      !nrfd_hold_o) else $error("hold while disabled");
   chk_hold_min: assert property (exec_i && hold_en_o && exec_kind_i != KIND_PLAIN |=>
      nrfd_hold_o [*8]) else $error("long hold cut short");
   // main scenarios reached
   cov_eoi: cover property (tx_valid_o && tx_ready_i && tx_eoi_o);
   cov_stall: cover property (tx_valid_o && !tx_ready_i);
   cov_release: cover property ($fell(nrfd_hold_o));
endmodule : gth_core_chk
bind gth_core gth_core_chk #(.HOLD_FMT_CYCLES(HOLD_FMT_CYCLES),
   .HOLD_WAVE_CYCLES(HOLD_WAVE_CYCLES)) u_gth_core_chk (.sys_clk_i(sys_clk_i),
   .sys_rst_i(sys_rst_i), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
   .tx_eoi_o(tx_eoi_o), .tx_ready_i(tx_ready_i), .term_disable_i(term_disable_i),
   .exec_i(exec_i), .exec_kind_i(exec_kind_i), .proc_done_i(proc_done_i),
   .dev_clear_i(dev_clear_i), .nrfd_hold_o(nrfd_hold_o), .term_sel_o(term_sel_o),
   .eoi_en_o(eoi_en_o), .hold_en_o(hold_en_o));

// file: verification/gth_bus_ctrl.sv
// bus controller stand-in that takes framed bytes
// assumes sys_clk_i shared with the core; slow_i asks for stalls
`timescale 1ns/1ps
module gth_bus_ctrl (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // stall request
   input wire logic slow_i,
   // handshake toward the core
   output logic tx_ready_o
);
   logic [1:0] cnt_q;
   // slow mode takes one cycle in four, enough to fill the buffer
   always_ff @(posedge sys_clk_i) begin
      cnt_q <= sys_rst_i ? 2'h0 : cnt_q + 2'h1;
      tx_ready_o <= !sys_rst_i && (!slow_i || cnt_q == 2'h3);
   end
endmodule : gth_bus_ctrl

// file: verification/testbench.sv
// self-checking bench for gth_core against a byte queue model
// assumes gth_bus_ctrl on the far side and short hold counts
`timescale 1ns/1ps
module testbench;
   import gth_pkg::*;
   localparam int FMT_N = 20;
   localparam int WAVE_N = 50;
   logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, src_valid_i = 1'b0, src_last_i = 1'b0;
   logic term_set_i = 1'b0, eh_set_i = 1'b0, term_disable_i = 1'b0, exec_i = 1'b0;
   logic proc_done_i = 1'b0, dev_clear_i = 1'b0, slow = 1'b0, m_eoi = 1'b1, m_hold = 1'b1;
   logic src_ready_o, tx_valid_o, tx_eoi_o, tx_ready_i, nrfd_hold_o, eoi_en_o, hold_en_o;
   logic [7:0] src_data_i = 8'h00, r = 8'h26, tx_data_o;
   logic [1:0] term_code_i = 2'h0, exec_kind_i = 2'h0, term_sel_o, m_term = 2'h0;
   logic [2:0] eh_code_i = 3'h0;
   logic [2:0] ec [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5};
   logic [8:0] q [$];
   int mismatches = 0, comparisons = 0, cyc = 0, n;
   gth_core #(.HOLD_FMT_CYCLES(FMT_N), .HOLD_WAVE_CYCLES(WAVE_N)) u_gth_core (.*);
   gth_bus_ctrl u_gth_bus_ctrl (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
      .slow_i(slow), .tx_ready_o(tx_ready_i));
   function automatic logic [7:0] nxt(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : nxt
   task automatic close_out();
      if (mismatches == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : close_out
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic tick(input int k = 1);
      repeat (k) @(posedge sys_clk_i);
   endtask : tick
   // settings sampled mid-cycle, away from the edge
   task automatic look();
      @(negedge sys_clk_i);
      chk({term_sel_o, eoi_en_o, hold_en_o}, {m_term, m_eoi, m_hold});
      tick();
   endtask : look
   task automatic put(input logic [7:0] b, input logic l);
      src_valid_i <= 1'b1;
      src_data_i <= b;
      src_last_i <= l;
      do @(negedge sys_clk_i); while (src_ready_o !== 1'b1);
      @(posedge sys_clk_i);
   endtask : put
   // expected framing of one whole transmission
   task automatic send(input int len);
      for (int i = 0; i < len; i++) begin
         r = nxt(r);
         q.push_back({(i == len - 1) && term_disable_i && m_eoi, r});
         put(r, i == len - 1);
      end
      src_valid_i <= 1'b0;
      src_last_i <= 1'b0;
      if (!term_disable_i) begin
         q.push_back({m_eoi && m_term[1], m_term[0] ? 8'h0A : 8'h0D});
         if (!m_term[1]) q.push_back({m_eoi, m_term[0] ? 8'h0D : 8'h0A});
      end
      // message end found by byte count, so a missing EOI cannot hang us
      while (q.size() != 0) tick();
      tick(2);
   endtask : send
   task automatic apply(input logic [1:0] t, input logic [2:0] e);
      term_set_i <= 1'b1;
      term_code_i <= t;
      eh_set_i <= 1'b1;
      eh_code_i <= e;
      tick();
      term_set_i <= 1'b0;
      eh_set_i <= 1'b0;
      proc_done_i <= 1'b1;
      tick();
      proc_done_i <= 1'b0;
      tick();
      m_term = t;
      // code 0 keeps both, code 1 drops EOI only, code 2 drops hold-off only, code 4 drops both, others leave the model as it was
      case (e)
         3'h0: {m_eoi, m_hold} = 2'b11;
         3'h1: {m_eoi, m_hold} = 2'b01;
         3'h2: {m_eoi, m_hold} = 2'b10;
         3'h4: {m_eoi, m_hold} = 2'b00;
         default: ;
      endcase
   endtask : apply
   // hold measured from the processing edge; next exec only after release
   task automatic hold(input logic [1:0] k, input int exp_n);
      exec_i <= 1'b1;
      exec_kind_i <= k;
      tick();
      exec_i <= 1'b0;
      proc_done_i <= 1'b1;
      tick();
      proc_done_i <= 1'b0;
      n = 0;
      do @(negedge sys_clk_i); while (nrfd_hold_o === 1'b1 && ++n < 200);
      chk(9'(n), 9'(exp_n));
      tick();
   endtask : hold
   // every byte the far side takes must match the model
   always @(posedge sys_clk_i) begin
      if (!sys_rst_i && tx_valid_o === 1'b1 && tx_ready_i === 1'b1)
         chk({tx_eoi_o, tx_data_o}, q.size() ? q.pop_front() : 9'bx);
   end
   // hang guard
   always @(posedge sys_clk_i) begin
      if (++cyc == 6000) begin
         mismatches++;
         close_out();
      end
   end
   initial begin
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end
   initial begin
      tick(3);
      sys_rst_i <= 1'b0;
      tick();
      look();
      for (int i = 0; i < 20; i++) begin
         apply(2'(i % 4), ec[i / 4]);
         look();
         r = nxt(r);
         term_disable_i <= r[0];
         slow <= r[1];
         tick();
         send(1 + int'(r[4:2]));
      end
      dev_clear_i <= 1'b1;
      tick();
      dev_clear_i <= 1'b0;
      {m_term, m_eoi, m_hold} = 4'h3;
      tick();
      look();
      // a plain command releases one cycle after processing; timed kinds release their count of cycles after it
      hold(KIND_PLAIN, 1);
      hold(KIND_FMT, FMT_N);
      hold(KIND_WAVE, WAVE_N);
      apply(2'h0, 3'h2);
      hold(KIND_PLAIN, 0);
      close_out();
   end
endmodule : testbench
